// ===== charge_time_edge_control.sv
// Edge control unit of the charge time measurement block with its APB register.
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps
module charge_time_edge_control (
    input  wire logic        pclk,                // Peripheral clock, 100 MHz.
    input  wire logic        presetn,             // Asynchronous reset, active low.
    input  wire logic        psel,                // APB select.
    input  wire logic        penable,             // APB enable.
    input  wire logic        pwrite,              // APB direction.
    input  wire logic [11:0] paddr,               // APB byte address.
    input  wire logic [31:0] pwdata,              // APB write data.
    input  wire logic [3:0]  pstrb,               // APB byte strobes.
    output logic             pready,              // APB ready.
    output logic [31:0]      prdata,              // APB read data.
    output logic             pslverr,             // APB error.
    input  wire logic [2:0]  comparator_output,   // Comparators three, two, one.
    input  wire logic [2:0]  capture_event,       // Capture units three, two, one.
    input  wire logic        compare_event,       // Compare unit one event.
    input  wire logic        timer_event,         // Timer one event.
    input  wire logic [7:0]  external_edge_pin,   // Edge pins eight down to one.
    input  wire logic [4:0]  second_edge_pin,     // Edge pins thirteen down to nine.
    input  wire logic        device_idle,         // Device idle request.
    output logic             unit_active,         // Unit enabled and not idle-stopped.
    output logic             current_discharge,   // Grounds the current source output.
    output logic             first_edge_flag,     // First edge status.
    output logic             second_edge_flag,    // Second edge status.
    output logic             time_generation_enable, // Delay generation on.
    output logic             trigger_output_enable,  // Trigger output on.
    output logic [5:0]       current_trim,        // Current trim.
    output logic [1:0]       current_range        // Current range.
);
    localparam int NUM_ASYNC = 22;

    typedef struct packed {
        logic [31:0]          ctrl;
        logic [NUM_ASYNC-1:0] s1;
        logic [NUM_ASYNC-1:0] s2;
        logic [NUM_ASYNC-1:0] s3;
        logic [NUM_ASYNC-1:0] filt;
        logic                 ready;
        logic                 err;
        logic [31:0]          rdata;
        logic                 active;
    } top_state_t;

    top_state_t  state_ff;
    top_state_t  nxt_state;
    logic [NUM_ASYNC-1:0] raw;
    logic [NUM_ASYNC-1:0] stable;
    logic        hit1;
    logic        hit2;
    logic        setup;
    logic        hit_addr;
    logic [31:0] bmask;

    edge_chan_if ch1 ();
    edge_chan_if ch2 ();

    // ==========================================================
    // Input synchronisers; a change counts once stages two and three agree.
    // The idle request rides in the top bit so that it is filtered like every source.
    assign raw = {device_idle, second_edge_pin, comparator_output, capture_event, external_edge_pin,
                  compare_event, timer_event};

    // Filtered levels; a disagreement between stages two and three keeps the last agreed value.
    assign stable = state_ff.filt;

    // ==========================================================
    // Channel source tables. Index order matches the source codes.
    // First channel: pins 1 and 2 are swapped in codes 3 and 2.
    assign ch1.sources = {stable[15:13], stable[12:10], stable[9:4], stable[2], stable[3],
                          stable[1], stable[0]};
    // Second channel: comparators, bus clock tick, captures, pins 13..9, pins 1 and 2.
    assign ch2.sources = {stable[15:13], 1'b1, stable[12:10], stable[20:16], stable[2],
                          stable[3], stable[1], stable[0]};
    assign ch1.sens = state_ff.ctrl[edge_ctl_pkg::FIRST_SENS_BIT];
    assign ch1.pol  = state_ff.ctrl[edge_ctl_pkg::FIRST_POL_BIT];
    assign ch1.sel  = state_ff.ctrl[edge_ctl_pkg::FIRST_SRC_LSB +: edge_ctl_pkg::SRC_WIDTH];
    assign ch2.sens = state_ff.ctrl[edge_ctl_pkg::SECOND_SENS_BIT];
    assign ch2.pol  = state_ff.ctrl[edge_ctl_pkg::SECOND_POL_BIT];
    assign ch2.sel  = state_ff.ctrl[edge_ctl_pkg::SECOND_SRC_LSB +: edge_ctl_pkg::SRC_WIDTH];
    assign hit1 = ch1.hit;
    assign hit2 = ch2.hit;

    edge_detector u_first (
        .pclk    (pclk),
        .presetn (presetn),
        .chan    (ch1)
    );

    edge_detector u_second (
        .pclk    (pclk),
        .presetn (presetn),
        .chan    (ch2)
    );

    // ==========================================================
    // APB decode: zero wait states, unmapped addresses answer with an error.
    assign setup    = psel & ~penable;
    assign hit_addr = (paddr == edge_ctl_pkg::CONTROL_OFFSET);
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            bmask[b*8 +: 8] = {8{pstrb[b]}};
        end
    end

    // Next state: bus write first, then hardware flag sets on top so a set wins.
    always_comb begin
        nxt_state       = state_ff;
        nxt_state.s1    = raw;
        nxt_state.s2    = state_ff.s1;
        nxt_state.s3    = state_ff.s2;
        for (int i = 0; i < NUM_ASYNC; i++) begin
            if (state_ff.s2[i] == state_ff.s3[i]) begin
                nxt_state.filt[i] = state_ff.s3[i];
            end
        end
        nxt_state.ready = setup;
        nxt_state.err   = setup & ~hit_addr;
        nxt_state.rdata = (setup & ~pwrite & hit_addr) ? state_ff.ctrl : edge_ctl_pkg::SLVERR_DATA;
        if (psel && penable && pwrite && hit_addr) begin
            nxt_state.ctrl = (state_ff.ctrl & ~(bmask & edge_ctl_pkg::CONTROL_WMASK))
                           | (pwdata & bmask & edge_ctl_pkg::CONTROL_WMASK);
        end
        nxt_state.active = state_ff.ctrl[edge_ctl_pkg::ENABLE_BIT]
                         & ~(state_ff.ctrl[edge_ctl_pkg::IDLE_STOP_BIT] & stable[NUM_ASYNC-1]);
        if (state_ff.active && state_ff.ctrl[edge_ctl_pkg::EDGE_GATE_BIT]) begin
            if (hit1) begin
                nxt_state.ctrl[edge_ctl_pkg::FIRST_FLAG_BIT] = 1'b1;
            end
            if (hit2 && (!state_ff.ctrl[edge_ctl_pkg::EDGE_ORDER_BIT]
                         || state_ff.ctrl[edge_ctl_pkg::FIRST_FLAG_BIT])) begin
                nxt_state.ctrl[edge_ctl_pkg::SECOND_FLAG_BIT] = 1'b1;
            end
        end
    end

    // Registers all state; every field clears at reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff      <= '0;
            state_ff.ctrl <= edge_ctl_pkg::CONTROL_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ==========================================================
    // Outputs straight from flip-flops.
    assign pready                 = state_ff.ready;
    assign pslverr                = state_ff.err;
    assign prdata                 = state_ff.rdata;
    assign unit_active            = state_ff.active;
    assign current_discharge      = state_ff.ctrl[edge_ctl_pkg::DISCHARGE_BIT];
    assign first_edge_flag        = state_ff.ctrl[edge_ctl_pkg::FIRST_FLAG_BIT];
    assign second_edge_flag       = state_ff.ctrl[edge_ctl_pkg::SECOND_FLAG_BIT];
    assign time_generation_enable = state_ff.ctrl[edge_ctl_pkg::TIME_GEN_BIT];
    assign trigger_output_enable  = state_ff.ctrl[edge_ctl_pkg::TRIGGER_OUT_BIT];
    assign current_trim           = state_ff.ctrl[edge_ctl_pkg::TRIM_LSB +: 6];
    assign current_range          = state_ff.ctrl[edge_ctl_pkg::RANGE_LSB +: 2];
endmodule

// ===== edge_ctl_if.sv
// Interface that carries one edge channel's configuration and result.
`timescale 1ns/100ps
interface edge_chan_if;
    logic                  sens;    // 1 edge, 0 level.
    logic                  pol;     // 1 rising, 0 falling.
    logic [15:0]           sources; // Synchronised sources.
    logic [3:0]            sel;     // Source code.
    logic                  hit;     // Qualifying event.
    modport ctl (output sens, pol, sources, sel, input hit);
    modport det (input sens, pol, sources, sel, output hit);
endinterface

// ===== edge_ctl_pkg.sv
// Package with register layout, reset values and source codes of the edge control unit.
package edge_ctl_pkg;

    // ==========================================================
    // Register map.
    localparam logic [11:0] CONTROL_OFFSET = 12'h000;
    localparam logic [31:0] CONTROL_RESET  = 32'h0000_0000;
    localparam logic [31:0] CONTROL_WMASK  = 32'hFFFC_BFFF;
    localparam logic [31:0] SLVERR_DATA    = 32'h0000_0000;

    // ==========================================================
    // Field positions.
    localparam int FIRST_SENS_BIT   = 31;
    localparam int FIRST_POL_BIT    = 30;
    localparam int FIRST_SRC_LSB    = 26;
    localparam int SECOND_FLAG_BIT  = 25;
    localparam int FIRST_FLAG_BIT   = 24;
    localparam int SECOND_SENS_BIT  = 23;
    localparam int SECOND_POL_BIT   = 22;
    localparam int SECOND_SRC_LSB   = 18;
    localparam int ENABLE_BIT       = 15;
    localparam int IDLE_STOP_BIT    = 13;
    localparam int TIME_GEN_BIT     = 12;
    localparam int EDGE_GATE_BIT    = 11;
    localparam int EDGE_ORDER_BIT   = 10;
    localparam int DISCHARGE_BIT    = 9;
    localparam int TRIGGER_OUT_BIT  = 8;
    localparam int TRIM_LSB         = 2;
    localparam int RANGE_LSB        = 0;
    localparam int SRC_WIDTH        = 4;
    localparam int NUM_SOURCES      = 16;

    // ==========================================================
    // Channel one source codes; channel two uses the same index space.
    localparam logic [3:0] SRC_TIMER_ONE   = 4'h0;
    localparam logic [3:0] SRC_COMPARE_ONE = 4'h1;
    localparam logic [3:0] SRC_COMP_TWO    = 4'hE;

endpackage

// ===== edge_ctl_properties.sv
// Checker of the edge control unit's register port and status outputs.
`timescale 1ns/100ps
module edge_ctl_properties (
    input wire logic        pclk,              // Peripheral clock.
    input wire logic        presetn,           // Reset, active low.
    input wire logic        psel,              // APB select.
    input wire logic        penable,           // APB enable.
    input wire logic        pwrite,            // APB direction.
    input wire logic [11:0] paddr,             // APB address.
    input wire logic [31:0] pwdata,            // APB write data.
    input wire logic [3:0]  pstrb,             // APB strobes.
    input wire logic        pready,            // APB ready.
    input wire logic [31:0] prdata,            // APB read data.
    input wire logic        pslverr,           // APB error.
    input wire logic        unit_active,       // Unit running.
    input wire logic        current_discharge, // Discharge output.
    input wire logic        first_edge_flag,   // First status.
    input wire logic        second_edge_flag,  // Second status.
    input wire logic [5:0]  current_trim,      // Trim output.
    input wire logic [1:0]  current_range      // Range output.
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================================
    // Completed writes to the control register.
    logic wr_done;
    assign wr_done = psel && penable && pready && pwrite && paddr == 12'h000;
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_write;
        s_setup ##1 wr_done;
    endsequence
    AST_ANSWER: assert property (s_setup |=> pready) else $error("no answer after setup");
    AST_ONE_BEAT: assert property (pready |=> !pready) else $error("ready longer than one cycle");
    AST_UNMAPPED: assert property (pready && paddr != 12'h000 |-> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    AST_RSVD_ZERO: assert property (pready && !pwrite |-> prdata[17:16] == 2'b00 && !prdata[14])
        else $error("reserved bits read nonzero");
    AST_DISCHARGE: assert property (s_write ##0 pstrb[1] |=> current_discharge == $past(pwdata[9]))
        else $error("discharge bit not written");
    AST_TRIM: assert property (s_write ##0 pstrb[0] |=> {current_trim, current_range} == $past(pwdata[7:0]))
        else $error("trim or range not written");
    AST_FIRST_HOLD: assert property (first_edge_flag && !wr_done |=> first_edge_flag)
        else $error("first flag dropped without write");
    AST_SECOND_HOLD: assert property (second_edge_flag && !wr_done |=> second_edge_flag)
        else $error("second flag dropped without write");
    AST_FLAG_CAUSE: assert property ($rose(first_edge_flag) |-> $past(unit_active) || $past(wr_done))
        else $error("first flag set while unit idle");
endmodule
bind charge_time_edge_control edge_ctl_properties i_edge_ctl_properties (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .unit_active, .current_discharge, .first_edge_flag,
    .second_edge_flag, .current_trim, .current_range);

// ===== edge_detector.sv
// One edge channel: source select and edge or level qualification.
`timescale 1ns/100ps
module edge_detector (
    input  wire logic  pclk,     // Peripheral clock.
    input  wire logic  presetn,  // Asynchronous reset, active low.
    edge_chan_if.det   chan      // Channel configuration and result.
);
    typedef struct packed {
        logic prev;
    } det_state_t;

    det_state_t state_ff;
    det_state_t nxt_state;
    logic       cur;

    // Selects one of sixteen sources and applies polarity.
    always_comb begin
        cur = chan.sources[chan.sel] ~^ chan.pol;
        nxt_state.prev = cur;
    end

    // Edge mode needs a low to high change of the polarised input; level mode needs it high.
    assign chan.hit = chan.sens ? (cur & ~state_ff.prev) : cur;

    // Registers the previous polarised value.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end
endmodule

// ===== edge_source_model.sv
// Model of the trigger sources around the unit, indexed by source code.
`timescale 1ns/100ps
module edge_source_model (
    input wire logic        pclk,              // Peripheral clock.
    input wire logic        presetn,           // Reset, active low.
    input wire logic [21:0] want,              // Requested source levels.
    output logic [2:0]      comparator_output, // Comparators.
    output logic [2:0]      capture_event,     // Captures.
    output logic            compare_event,     // Compare event.
    output logic            timer_event,       // Timer event.
    output logic [7:0]      external_edge_pin, // Pins eight to one.
    output logic [4:0]      second_edge_pin,   // Pins thirteen to nine.
    output logic            device_idle        // Idle request.
);
    logic [21:0] src_ff;
    // Sources move one clock after a request, like registered peripheral outputs.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) src_ff <= 22'h00_0000;
        else src_ff <= want;
    end
    // Bit n of the vector is the source that channel one code n selects.
    assign timer_event       = src_ff[0];
    assign compare_event     = src_ff[1];
    assign external_edge_pin = {src_ff[9:4], src_ff[2], src_ff[3]};
    assign capture_event     = src_ff[12:10];
    assign comparator_output = src_ff[15:13];
    assign second_edge_pin   = src_ff[20:16];
    assign device_idle       = src_ff[21];
endmodule

// ===== test_charge_time_edge_control.sv
// Testbench of the edge control unit, driven over APB.
`timescale 1ns/100ps
module test_charge_time_edge_control;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd;
    logic [21:0] want = 0;
    logic pready, pslverr, unit_active, current_discharge, first_edge_flag, second_edge_flag;
    logic time_generation_enable, trigger_output_enable, compare_event, timer_event, device_idle;
    logic [31:0] prdata;
    logic [5:0] current_trim;
    logic [2:0] comparator_output, capture_event;
    logic [1:0] current_range;
    logic [7:0] external_edge_pin;
    logic [4:0] second_edge_pin;
    int error_cnt = 0, cmp_count = 0;
    always #5 pclk = ~pclk;
    charge_time_edge_control i_charge_time_edge_control (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb(4'hF), .pready, .prdata, .pslverr, .comparator_output, .capture_event, .compare_event,
        .timer_event, .external_edge_pin, .second_edge_pin, .device_idle, .unit_active, .current_discharge,
        .first_edge_flag, .second_edge_flag, .time_generation_enable, .trigger_output_enable, .current_trim,
        .current_range);
    edge_source_model i_edge_source_model (.pclk, .presetn, .want, .comparator_output, .capture_event,
        .compare_event, .timer_event, .external_edge_pin, .second_edge_pin, .device_idle);
    // One APB transfer, entered just after a rising edge; data and error are taken at the ready edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Sets the source levels and lets them pass synchroniser and detector.
    task automatic drive(input logic [21:0] v);
        want <= v;
        repeat (8) @(posedge pclk);
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Main sequence: register map, every channel one source code, order, gate and idle.
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 12'h000, 0);
        check(rd, 32'h0000_0000);
        check({22'h0, time_generation_enable, trigger_output_enable, current_trim, current_range}, 32'h0);
        apb(1, 12'h000, 32'hFFFF_FFFF);
        check({22'h0, time_generation_enable, trigger_output_enable, current_trim, current_range}, 32'h3FF);
        apb(0, 12'h000, 0);
        check(rd, 32'hFFFC_BFFF);
        check({31'h0, current_discharge}, 32'h1);
        apb(0, 12'h004, 0);
        check({rd[30:0], err}, 32'h1);
        $display("register test done");
        for (int c = 0; c < 16; c++) begin
            drive({21'h0, ~c[0]} << c);
            apb(1, 12'h000, 32'h8080_8800 | (32'(c[0]) << 30) | (32'(c) << 26));
            drive(want | (22'h1 << (c ^ 1)));
            check({31'h0, first_edge_flag}, 32'h0);
            drive(want ^ (22'h1 << c));
            check({31'h0, first_edge_flag}, 32'h1);
        end
        $display("source test done");
        drive(22'h0);
        apb(1, 12'h000, 32'hC0F8_9C00);
        drive(22'h00_4000);
        check({31'h0, second_edge_flag}, 32'h0);
        drive(22'h00_4001);
        check({31'h0, first_edge_flag}, 32'h1);
        drive(22'h00_0001);
        drive(22'h00_4001);
        check({31'h0, second_edge_flag}, 32'h1);
        apb(1, 12'h000, 32'hC000_8000);
        drive(22'h0);
        drive(22'h1);
        check({31'h0, first_edge_flag}, 32'h0);
        apb(1, 12'h000, 32'h0000_A000);
        drive(22'h20_0000);
        check({31'h0, unit_active}, 32'h0);
        drive(22'h0);
        check({31'h0, unit_active}, 32'h1);
        apb(1, 12'h000, 32'h40E0_8800);
        drive(22'h10_0001);
        check({30'h0, second_edge_flag, first_edge_flag}, 32'h3);
        apb(1, 12'h000, 32'h40E0_8800);
        check({30'h0, second_edge_flag, first_edge_flag}, 32'h1);
        $display("sequence test done");
        end_sim();
    end
    // Watchdog against a hung handshake.
    initial begin
        #100000;
        error_cnt++;
        end_sim();
    end
endmodule
